// ### rtl/sms_fifo.sv
// flip-flop fifo with valid/ready on both sides
module sms_fifo
	import sms_pkg::*;
#(
	parameter int W     = BYTE_W,
	parameter int DEPTH = FIFO_DEPTH
) (
	input  wire logic         clk_i,
	input  wire logic         rst_b_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic [W-1:0]      out_data_o
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem_ff [DEPTH];
	logic [AW:0]  wr_ptr_ff;
	logic [AW:0]  rd_ptr_ff;
	logic         push;
	logic         pop;

	assign out_valid_o = wr_ptr_ff != rd_ptr_ff;
	assign in_ready_o  = (wr_ptr_ff[AW] == rd_ptr_ff[AW])
		|| (wr_ptr_ff[AW-1:0] != rd_ptr_ff[AW-1:0]);
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;
	assign out_data_o  = mem_ff[rd_ptr_ff[AW-1:0]];

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_ff[wr_ptr_ff[AW-1:0]] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
		end else begin
			if (push) begin
				wr_ptr_ff <= wr_ptr_ff + 1'b1;
			end
			if (pop) begin
				rd_ptr_ff <= rd_ptr_ff + 1'b1;
			end
		end
	end
endmodule

// ### rtl/sms_pkg.sv
// shared constants and types of the serial port with slave-select modes
package sms_pkg;
	localparam int          BYTE_W       = 8;
	localparam int          FIFO_DEPTH   = 32;
	localparam int          SYS_CLK_MHZ  = 100;
	// master serial clock half period, least time in ns
	localparam int          SCK_HALF_NS  = 80;
	localparam int          SCK_HALF_CYC = (SCK_HALF_NS * SYS_CLK_MHZ + 999) / 1000;
	// least select setup the far master must give, in system clocks
	localparam int          NSS_SETUP_CYC = 2;
	localparam logic [1:0]  SEL_3WIRE    = 2'h0;
	localparam logic [1:0]  SEL_4WIRE_IN = 2'h1;
	localparam logic [1:0]  SEL_RESET    = 2'h1;
	localparam int          SEL_OUT_BIT  = 1;
	localparam int          SEL_LVL_BIT  = 0;
	localparam logic [2:0]  BIT_LAST     = 3'h7;
	localparam logic [2:0]  BIT_FIRST    = 3'h0;
	// synchroniser lanes
	localparam int          SY_W         = 3;
	localparam int          SY_NSS       = 0;
	localparam int          SY_TGL       = 1;
	localparam int          SY_MISO      = 2;
	localparam logic [2:0]  SY_RST       = 3'h1;
	typedef enum logic {MST_IDLE, MST_SHIFT} sms_mst_state_t;
endpackage

// ### rtl/sms_spi.sv
// full-duplex serial port, master or slave, with slave-select modes
// How it works
// - master drives the data-out line; slave takes it as input.
// - every byte moves most significant bit first on both lines.
// - as master the data-out line carries the shift register top bit.
// - master samples the data-in line; slave drives it.
// - slave data line floats when disabled or a deselected 4-wire slave.
// - 3-wire slave always drives its holding register top bit before a byte's first edge, then its shift register top bit.
// - serial clock driven only as master; slave takes it as input.
// - 4-wire slave ignores serial clock while select is high.
// - select mode 00: 3-wire, slave is always selected.
// - select mode 01: 4-wire, select pin is an input choosing the slave.
// - master in mode 01 stops on a falling select input.
// - select mode 1x: select pin is an output at the lower mode bit.
// - select pin routed to a pin except in mode 00.
// - master sets the done flag after the last bit shifts.
// - mode fault clears both enables, sets fault flag until FAULT_CLR_I clears it.
// - slave counts 8 clock edges, then stores the byte unless done is still set, sets done.
module sms_spi
	import sms_pkg::*;
#(
	parameter int HALF_CYC = SCK_HALF_CYC,
	parameter int DEPTH    = FIFO_DEPTH
) (
	input  wire logic              SYS_CLK_I,
	input  wire logic              RST_B_I,
	input  wire logic              CFG_WR_I,
	input  wire logic              CFG_PORT_EN_I,
	input  wire logic              CFG_MASTER_EN_I,
	input  wire logic [1:0]        CFG_SEL_MODE_I,
	input  wire logic              DONE_CLR_I,
	input  wire logic              FAULT_CLR_I,
	input  wire logic              OVRN_CLR_I,
	input  wire logic              TX_VALID_I,
	output logic                   TX_READY_O,
	input  wire logic [BYTE_W-1:0] TX_DATA_I,
	output logic                   RX_VALID_O,
	output logic [BYTE_W-1:0]      RX_DATA_O,
	output logic                   PORT_EN_O,
	output logic                   MASTER_EN_O,
	output logic [1:0]             SEL_MODE_O,
	output logic                   DONE_FLAG_O,
	output logic                   FAULT_FLAG_O,
	output logic                   OVRN_FLAG_O,
	output logic                   BUSY_O,
	input  wire logic              SLV_SCK_I,
	output logic                   SCK_O,
	output logic                   SCK_OE_O,
	input  wire logic              MOSI_I,
	output logic                   MOSI_O,
	output logic                   MOSI_OE_O,
	input  wire logic              MISO_I,
	output logic                   MISO_O,
	output logic                   MISO_OE_O,
	input  wire logic              NSS_I,
	output logic                   NSS_O,
	output logic                   NSS_OE_O,
	output logic                   NSS_ROUTED_O
);
	localparam int HW = $clog2(HALF_CYC + 1);
	localparam logic [HW-1:0] HALF_LAST = HW'(HALF_CYC - 1);

	logic                   port_en_ff;
	logic                   master_en_ff;
	logic [1:0]             sel_mode_ff;
	logic                   done_flag_ff;
	logic                   fault_flag_ff;
	logic                   ovrn_flag_ff;
	logic [SY_W-1:0]        sy1_ff;
	logic [SY_W-1:0]        sy2_ff;
	logic [SY_W-1:0]        sy3_ff;
	logic [SY_W-1:0]        lvl_ff;
	logic [SY_W-1:0]        nxt_lvl;
	sms_mst_state_t         mst_state_ff;
	logic [BYTE_W-1:0]      mst_sh_ff;
	logic [HW-1:0]          half_ff;
	logic [2:0]             mst_cnt_ff;
	logic                   mst_sck_ff;
	logic                   mst_rx_bit_ff;
	logic [BYTE_W-1:0]      slv_tx_ff;
	logic                   slv_full_ff;
	logic [BYTE_W-1:0]      rx_data_ff;
	logic                   rx_valid_ff;
	logic [2:0]             lk_cnt_ff;
	logic [BYTE_W-1:0]      lk_sh_ff;
	logic [BYTE_W-1:0]      lk_rx_ff;
	logic                   lk_tgl_ff;
	logic                   lk_run_b;
	logic                   is_master;
	logic                   is_slave;
	logic                   slv_sel;
	logic                   nss_fall;
	logic                   slv_evt;
	logic                   mode_fault;
	logic                   mst_start;
	logic                   half_tick;
	logic                   mst_fin;
	logic                   slv_load;
	logic                   byte_done;
	logic [BYTE_W-1:0]      byte_rx;
	logic                   q_valid;
	logic [BYTE_W-1:0]      q_data;

	assign is_master = port_en_ff && master_en_ff;
	assign is_slave  = port_en_ff && !master_en_ff;
	// raw pin used here so select setup of two clocks is enough
	assign slv_sel   = (sel_mode_ff == SEL_3WIRE)
		|| (sel_mode_ff == SEL_4WIRE_IN && !NSS_I);

	// transmit buffer: back-pressure reaches the writer through TX_READY_O
	sms_fifo #(.W(BYTE_W), .DEPTH(DEPTH)) u_txq (
		.clk_i       (SYS_CLK_I),
		.rst_b_i     (RST_B_I),
		.in_valid_i  (TX_VALID_I),
		.in_ready_o  (TX_READY_O),
		.in_data_i   (TX_DATA_I),
		.out_valid_o (q_valid),
		.out_ready_i (mst_start || slv_load),
		.out_data_o  (q_data)
	);

	// three-stage synchronisers; a change counts once stages 2 and 3 agree
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_B_I) begin
			sy1_ff <= SY_RST;
			sy2_ff <= SY_RST;
			sy3_ff <= SY_RST;
			lvl_ff <= SY_RST;
		end else begin
			sy1_ff <= {MISO_I, lk_tgl_ff, NSS_I};
			sy2_ff <= sy1_ff;
			sy3_ff <= sy2_ff;
			lvl_ff <= nxt_lvl;
		end
	end
	assign nxt_lvl  = (~(sy2_ff ^ sy3_ff) & sy3_ff)
		| ((sy2_ff ^ sy3_ff) & lvl_ff);
	assign nss_fall = lvl_ff[SY_NSS] && !nxt_lvl[SY_NSS];
	assign slv_evt  = lvl_ff[SY_TGL] != nxt_lvl[SY_TGL];

	assign mode_fault = master_en_ff && sel_mode_ff == SEL_4WIRE_IN
		&& nss_fall;

	// configuration; a fault outranks a write in the same cycle
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_B_I) begin
			port_en_ff   <= 1'b0;
			master_en_ff <= 1'b0;
			sel_mode_ff  <= SEL_RESET;
		end else if (mode_fault) begin
			port_en_ff   <= 1'b0;
			master_en_ff <= 1'b0;
		end else if (CFG_WR_I) begin
			port_en_ff   <= CFG_PORT_EN_I;
			master_en_ff <= CFG_MASTER_EN_I;
			sel_mode_ff  <= CFG_SEL_MODE_I;
		end
	end

	// master engine, clock phase 0 and idle-low clock
	assign mst_start = mst_state_ff == MST_IDLE && is_master && q_valid;
	assign half_tick = mst_state_ff == MST_SHIFT && half_ff == HALF_LAST;
	assign mst_fin   = half_tick && mst_sck_ff && mst_cnt_ff == BIT_LAST;

	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_B_I) begin
			mst_state_ff  <= MST_IDLE;
			mst_sh_ff     <= '0;
			half_ff       <= '0;
			mst_cnt_ff    <= BIT_FIRST;
			mst_sck_ff    <= 1'b0;
			mst_rx_bit_ff <= 1'b0;
		end else begin
			unique case (mst_state_ff)
				MST_IDLE: begin
					half_ff    <= '0;
					mst_cnt_ff <= BIT_FIRST;
					mst_sck_ff <= 1'b0;
					if (mst_start) begin
						mst_sh_ff    <= q_data;
						mst_state_ff <= MST_SHIFT;
					end
				end
				MST_SHIFT: begin
					half_ff <= half_tick ? '0 : half_ff + 1'b1;
					if (!is_master) begin
						// fault or disable drops the byte at once
						mst_state_ff <= MST_IDLE;
						mst_sck_ff   <= 1'b0;
					end else if (half_tick && !mst_sck_ff) begin
						mst_sck_ff    <= 1'b1;
						mst_rx_bit_ff <= lvl_ff[SY_MISO];
					end else if (half_tick) begin
						mst_sck_ff <= 1'b0;
						mst_sh_ff  <= {mst_sh_ff[BYTE_W-2:0],
							mst_rx_bit_ff};
						mst_cnt_ff <= mst_cnt_ff + 1'b1;
						if (mst_cnt_ff == BIT_LAST) begin
							mst_state_ff <= MST_IDLE;
						end
					end
				end
			endcase
		end
	end

	// slave transmit holding register; stays put while a byte shifts
	assign slv_load = is_slave && !slv_full_ff && q_valid;
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_B_I) begin
			slv_tx_ff   <= '0;
			slv_full_ff <= 1'b0;
		end else if (slv_load) begin
			slv_tx_ff   <= q_data;
			slv_full_ff <= 1'b1;
		end else if (slv_evt || !is_slave) begin
			slv_full_ff <= 1'b0;
		end
	end

	// link side, clocked by the far master; held clear when not selected
	assign lk_run_b = is_slave && slv_sel;
	always_ff @(posedge SLV_SCK_I or negedge lk_run_b) begin
		if (!lk_run_b) begin
			lk_cnt_ff <= BIT_FIRST;
			lk_sh_ff  <= '0;
		end else begin
			lk_cnt_ff <= lk_cnt_ff + 1'b1;
			if (lk_cnt_ff == BIT_FIRST) begin
				lk_sh_ff <= {slv_tx_ff[BYTE_W-2:0], MOSI_I};
			end else begin
				lk_sh_ff <= {lk_sh_ff[BYTE_W-2:0], MOSI_I};
			end
		end
	end

	// the toggle survives deselect so no false byte event appears
	always_ff @(posedge SLV_SCK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			lk_rx_ff  <= '0;
			lk_tgl_ff <= 1'b0;
		end else if (lk_run_b && lk_cnt_ff == BIT_LAST) begin
			lk_rx_ff  <= {lk_sh_ff[BYTE_W-2:0], MOSI_I};
			lk_tgl_ff <= !lk_tgl_ff;
		end
	end

	// received bytes and flags; a set outranks a clear
	assign byte_done = mst_fin || (slv_evt && is_slave);
	assign byte_rx   = mst_fin ? {mst_sh_ff[BYTE_W-2:0], mst_rx_bit_ff}
		: lk_rx_ff;

	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_B_I) begin
			rx_data_ff  <= '0;
			rx_valid_ff <= 1'b0;
		end else begin
			// a slave byte over an unread one is lost
			rx_valid_ff <= byte_done && !(is_slave && done_flag_ff);
			if (byte_done && !(is_slave && done_flag_ff)) begin
				rx_data_ff <= byte_rx;
			end
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_B_I) begin
			done_flag_ff <= 1'b0;
		end else if (byte_done) begin
			done_flag_ff <= 1'b1;
		end else if (DONE_CLR_I) begin
			done_flag_ff <= 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_B_I) begin
			fault_flag_ff <= 1'b0;
		end else if (mode_fault) begin
			fault_flag_ff <= 1'b1;
		end else if (FAULT_CLR_I) begin
			fault_flag_ff <= 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_B_I) begin
			ovrn_flag_ff <= 1'b0;
		end else if (slv_evt && is_slave && done_flag_ff) begin
			ovrn_flag_ff <= 1'b1;
		end else if (OVRN_CLR_I) begin
			ovrn_flag_ff <= 1'b0;
		end
	end

	// pins
	assign MOSI_O    = mst_sh_ff[BYTE_W-1];
	assign MOSI_OE_O = is_master;
	// gated so a fault or disable mid-byte never leaves the clock high
	assign SCK_O     = mst_sck_ff && is_master;
	assign SCK_OE_O  = is_master;
	assign MISO_O    = (lk_cnt_ff == BIT_FIRST) ? slv_tx_ff[BYTE_W-1]
		: lk_sh_ff[BYTE_W-1];
	assign MISO_OE_O = is_slave && slv_sel;
	assign NSS_O     = sel_mode_ff[SEL_LVL_BIT];
	assign NSS_OE_O  = sel_mode_ff[SEL_OUT_BIT];
	assign NSS_ROUTED_O = sel_mode_ff != SEL_3WIRE;

	assign RX_VALID_O   = rx_valid_ff;
	assign RX_DATA_O    = rx_data_ff;
	assign PORT_EN_O    = port_en_ff;
	assign MASTER_EN_O  = master_en_ff;
	assign SEL_MODE_O   = sel_mode_ff;
	assign DONE_FLAG_O  = done_flag_ff;
	assign FAULT_FLAG_O = fault_flag_ff;
	assign OVRN_FLAG_O  = ovrn_flag_ff;
	assign BUSY_O       = mst_state_ff == MST_SHIFT;

	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (!RST_B_I);

	sequence fault_cause_s;
		MASTER_EN_O && SEL_MODE_O == SEL_4WIRE_IN && nss_fall;
	endsequence
	sequence fault_effect_s;
		!PORT_EN_O && !MASTER_EN_O && FAULT_FLAG_O;
	endsequence

	mosi_dir_a: assert property (
		MOSI_OE_O == (PORT_EN_O && MASTER_EN_O))
		else $error("data-out enable does not follow master role");
	msb_first_a: assert property (
		mst_start |=> MOSI_O == $past(q_data[BYTE_W-1]))
		else $error("master did not present top bit first");
	miso_float_a: assert property (
		(!PORT_EN_O || MASTER_EN_O || (SEL_MODE_O == SEL_4WIRE_IN
		&& NSS_I)) |-> !MISO_OE_O)
		else $error("slave data line driven while it must float");
	miso_3wire_a: assert property (
		(PORT_EN_O && !MASTER_EN_O && SEL_MODE_O == SEL_3WIRE)
		|-> MISO_OE_O)
		else $error("3-wire slave not driving its data line");
	sck_gen_a: assert property (
		!MASTER_EN_O |-> !SCK_OE_O && !SCK_O)
		else $error("serial clock driven outside master role");
	fault_stop_a: assert property (
		fault_cause_s |=> fault_effect_s ##1 !BUSY_O)
		else $error("mode fault did not disable the master");
	nss_out_a: assert property (
		SEL_MODE_O[SEL_OUT_BIT] |-> NSS_OE_O
		&& NSS_O == SEL_MODE_O[SEL_LVL_BIT])
		else $error("select output level wrong in mode 1x");
	nss_route_a: assert property (
		NSS_ROUTED_O == (SEL_MODE_O != SEL_3WIRE))
		else $error("select pin routing wrong");
	mst_done_a: assert property (
		(BUSY_O && mst_fin) |=> DONE_FLAG_O && RX_VALID_O && !BUSY_O)
		else $error("master byte end did not set done");
	slv_done_a: assert property (
		(slv_evt && is_slave && !DONE_FLAG_O) |=> DONE_FLAG_O
		&& RX_VALID_O && RX_DATA_O == $past(lk_rx_ff))
		else $error("slave byte not stored with done set");
	mst_len_a: assert property (
		mst_start |=> BUSY_O [*8])
		else $error("master byte ended too early");
endmodule

// ### testbench/sms_far.sv
// far-side partner: slave to our master, master to our slave
module sms_far #(
	parameter logic [7:0] FIRST = 8'h3C
) (
	input  wire logic sck_i,
	input  wire logic mosi_i,
	output logic      miso_o,
	output logic      slv_sck_o,
	output logic      slv_mosi_o,
	output logic      nss_o,
	input  wire logic slv_miso_i,
	input  wire logic slv_miso_oe_i
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] sh     = FIRST;
	logic       bit_in = 1'b0;
	logic       seen   = 1'b0;
	logic       rise   = 1'b0;
	int         cnt    = 0;
	logic [7:0] got_q[$];
	initial begin
		slv_sck_o = 1'b0;
		slv_mosi_o = 1'b0;
		nss_o = 1'b1;
	end
	assign miso_o = sh[7];
	always @(posedge sck_i) begin
		bit_in = mosi_i;
		rise = 1'b1;
	end
	// reply byte is the inverse of the one just heard, so it is predictable
	// a fall with no rise before it (unknown to low at reset) is no bit
	always @(negedge sck_i) begin
		if (rise) begin
			rise = 1'b0;
			sh = {sh[6:0], bit_in};
			cnt++;
			if (cnt == 8) begin
				got_q.push_back(sh);
				sh = ~sh;
				cnt = 0;
			end
		end
	end
	task automatic sel(input logic lvl);
		nss_o = lvl;
		#40;
	endtask
	// link clock runs only inside this task, idle low between frames
	task automatic byte8(input logic [7:0] b);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 7; i >= 0; i--) begin
			slv_mosi_o = b[i];
			#62.5;
			// undriven line is seen as the opposite of the last bit
			seen = slv_miso_oe_i ? slv_miso_i : ~seen;
			r[i] = seen;
			slv_sck_o = 1'b1;
			#62.5;
			slv_sck_o = 1'b0;
		end
		slv_mosi_o = ~slv_mosi_o;
		got_q.push_back(r);
		#150;
	endtask
endmodule

// ### testbench/sms_spi_test.sv
// self-checking bench of the serial port in master and slave roles
module sms_spi_test
	import sms_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin \
		err_total++; $display("BAD %s exp %h got %h", nm, ex, gt); end end
	logic       sys_clk = 1'b0, rst_b = 1'b1, cfg_wr = 1'b0, cfg_pe = 1'b0;
	logic       cfg_me = 1'b0, done_clr = 1'b0, fault_clr = 1'b0;
	logic       ovrn_clr = 1'b0, tx_valid = 1'b0, nss_x = 1'b1;
	logic [1:0] cfg_mode = 2'h0;
	logic [7:0] tx_data = 8'h00, rx_data, e, g, b, em, far_prev = 8'h3C;
	logic       tx_ready, rx_valid, port_en, master_en, done_flag, fault_flag;
	logic       ovrn_flag, busy, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
	logic       nss_o, nss_oe, nss_routed, far_miso, slv_sck, slv_mosi, far_nss;
	logic [1:0] sel_mode;
	logic       nss_w;
	logic [7:0] tx_q[$], exp_rx[$];
	int         err_total = 0, tests_run = 0, rx_cnt = 0, n0, k;
	int         seed = 32'hAC1D;
	assign nss_w = nss_oe ? nss_o : (far_nss & nss_x);
	always #5 sys_clk = ~sys_clk;
	sms_spi #(.HALF_CYC(SCK_HALF_CYC), .DEPTH(FIFO_DEPTH)) u_sms_spi (
		.SYS_CLK_I(sys_clk), .RST_B_I(rst_b), .CFG_WR_I(cfg_wr),
		.CFG_PORT_EN_I(cfg_pe), .CFG_MASTER_EN_I(cfg_me),
		.CFG_SEL_MODE_I(cfg_mode), .DONE_CLR_I(done_clr),
		.FAULT_CLR_I(fault_clr), .OVRN_CLR_I(ovrn_clr),
		.TX_VALID_I(tx_valid), .TX_READY_O(tx_ready), .TX_DATA_I(tx_data),
		.RX_VALID_O(rx_valid), .RX_DATA_O(rx_data), .PORT_EN_O(port_en),
		.MASTER_EN_O(master_en), .SEL_MODE_O(sel_mode),
		.DONE_FLAG_O(done_flag), .FAULT_FLAG_O(fault_flag),
		.OVRN_FLAG_O(ovrn_flag), .BUSY_O(busy), .SLV_SCK_I(slv_sck),
		.SCK_O(sck_o), .SCK_OE_O(sck_oe), .MOSI_I(slv_mosi),
		.MOSI_O(mosi_o), .MOSI_OE_O(mosi_oe), .MISO_I(far_miso),
		.MISO_O(miso_o), .MISO_OE_O(miso_oe), .NSS_I(nss_w), .NSS_O(nss_o),
		.NSS_OE_O(nss_oe), .NSS_ROUTED_O(nss_routed)
	);
	sms_far #(.FIRST(8'h3C)) u_sms_far (
		.sck_i(sck_o), .mosi_i(mosi_o), .miso_o(far_miso),
		.slv_sck_o(slv_sck), .slv_mosi_o(slv_mosi), .nss_o(far_nss),
		.slv_miso_i(miso_o), .slv_miso_oe_i(miso_oe)
	);
	always @(negedge sys_clk) begin
		if (rx_valid === 1'b1) begin
			rx_cnt++;
			em = exp_rx.pop_front();
			`CHK("rx_data", em, rx_data)
		end
	end
	task automatic close_out();
		if (err_total == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic cfg(input logic pe, me, input logic [1:0] m);
		@(negedge sys_clk);
		cfg_pe = pe;
		cfg_me = me;
		cfg_mode = m;
		cfg_wr = 1'b1;
		@(negedge sys_clk);
		cfg_wr = 1'b0;
	endtask
	task automatic pulse(ref logic s);
		@(negedge sys_clk);
		s = 1'b1;
		@(negedge sys_clk);
		s = 1'b0;
	endtask
	// master replies are the inverse of the previous byte sent
	task automatic push_n(input int n, input bit mst);
		for (int i = 0; i < n; i++) begin
			@(negedge sys_clk);
			tx_data = 8'($random(seed));
			tx_valid = 1'b1;
			tx_q.push_back(tx_data);
			if (mst) exp_rx.push_back(far_prev);
			far_prev = ~tx_data;
		end
		@(negedge sys_clk);
		tx_valid = 1'b0;
	endtask
	task automatic wait_rx(input int n, input int lim);
		for (k = 0; rx_cnt < n; k++) begin
			@(negedge sys_clk);
			if (k > lim) begin
				err_total++;
				close_out();
			end
		end
	endtask
	initial begin
		// a real falling edge clears the link-side flops as well
		#1;
		rst_b = 1'b0;
		repeat (5) @(negedge sys_clk);
		rst_b = 1'b1;
		@(negedge sys_clk);
		`CHK("rst_mode", SEL_RESET, sel_mode)
		`CHK("rst_route", 1'b1, nss_routed)
		`CHK("rst_miso_oe", 1'b0, miso_oe)
		`CHK("rst_sck_oe", 1'b0, sck_oe)
		// every select mode as master only
		for (int m = 0; m < 4; m++) begin
			cfg(1'b1, 1'b1, m[1:0]);
			`CHK("nss_oe", m[1], nss_oe)
			if (m[1]) `CHK("nss_lvl", m[0], nss_o)
			`CHK("routed", m != 0, nss_routed)
			`CHK("mosi_oe", 1'b1, mosi_oe)
			`CHK("sck_oe", 1'b1, sck_oe)
			`CHK("miso_oe", 1'b0, miso_oe)
		end
		cfg(1'b0, 1'b0, SEL_3WIRE);
		push_n(FIFO_DEPTH, 1'b1);
		`CHK("tx_full", 1'b0, tx_ready)
		cfg(1'b1, 1'b1, SEL_3WIRE);
		@(negedge sys_clk);
		`CHK("busy", 1'b1, busy)
		wait_rx(FIFO_DEPTH, FIFO_DEPTH * 140);
		`CHK("done", 1'b1, done_flag)
		`CHK("idle", 1'b0, busy)
		repeat (FIFO_DEPTH) begin
			g = u_sms_far.got_q.pop_front();
			e = tx_q.pop_front();
			`CHK("far_rx", e, g)
		end
		pulse(done_clr);
		cfg(1'b1, 1'b1, SEL_4WIRE_IN);
		@(negedge sys_clk);
		nss_x = 1'b0;
		for (k = 0; k < 10 && fault_flag !== 1'b1; k++) @(negedge sys_clk);
		`CHK("fault", 1'b1, fault_flag)
		`CHK("pe_fault", 1'b0, port_en)
		`CHK("me_fault", 1'b0, master_en)
		if (k == 10) close_out();
		nss_x = 1'b1;
		pulse(fault_clr);
		repeat (5) @(negedge sys_clk);
		`CHK("fault_clr", 1'b0, fault_flag)
		`CHK("pe_stays", 1'b0, port_en)
		push_n(3, 1'b0);
		cfg(1'b1, 1'b0, SEL_4WIRE_IN);
		repeat (10) @(negedge sys_clk);
		`CHK("miso_off", 1'b0, miso_oe)
		`CHK("sck_oe_slv", 1'b0, sck_oe)
		`CHK("mosi_oe_slv", 1'b0, mosi_oe)
		n0 = rx_cnt;
		u_sms_far.byte8(8'h5A);
		g = u_sms_far.got_q.pop_front();
		`CHK("ignored", n0, rx_cnt)
		b = 8'($random(seed));
		exp_rx.push_back(b);
		u_sms_far.sel(1'b0);
		`CHK("miso_on", 1'b1, miso_oe)
		u_sms_far.byte8(b);
		u_sms_far.sel(1'b1);
		wait_rx(n0 + 1, 20);
		g = u_sms_far.got_q.pop_front();
		e = tx_q.pop_front();
		`CHK("slv_tx4", e, g)
		pulse(done_clr);
		cfg(1'b1, 1'b0, SEL_3WIRE);
		`CHK("miso_3w", 1'b1, miso_oe)
		b = 8'($random(seed));
		exp_rx.push_back(b);
		u_sms_far.byte8(b);
		wait_rx(n0 + 2, 20);
		g = u_sms_far.got_q.pop_front();
		e = tx_q.pop_front();
		`CHK("slv_tx3", e, g)
		// done still set, so the next byte must be dropped
		u_sms_far.byte8(~b);
		repeat (10) @(negedge sys_clk);
		`CHK("ovrn", 1'b1, ovrn_flag)
		`CHK("no_rx", n0 + 2, rx_cnt)
		pulse(ovrn_clr);
		`CHK("ovrn_clr", 1'b0, ovrn_flag)
		close_out();
	end
endmodule
